// ### inc/amp_consts.svh
// Purpose: offsets, fields, reset values and timing of the amplifier block
// Assumes: included by its bare name; 8-bit register space
// Notes:   positions are bit indices within a register byte
`ifndef AMP_CONSTS_SVH
`define AMP_CONSTS_SVH

`define CH_COUNT         2
// register offsets
`define REG_FAULT_CAUSE  8'h01
`define REG_DIAG_RESULT  8'h02
`define REG_SWITCH_CTRL  8'h0A
`define REG_DIAG_CTRL    8'h0B
`define REG_OUTPUT_CTRL  8'h0C
`define REG_THERMAL      8'h13
// reset values
`define SWITCH_CTRL_RST  8'h0D
`define DIAG_CTRL_RST    8'h50
`define OUTPUT_CTRL_RST  8'h1F
`define THERMAL_RST      8'h00
// switching control fields
`define FREQ_LSB         0
`define WARN_CFG_LSB     2
`define PHASE180_BIT     5
`define FS_CODE_FAST     2'h0
`define FS_CODE_SLOW     2'h2
`define WARN_CLIP        2'h1
`define WARN_THERM       2'h2
`define WARN_BOTH        2'h3
// diag/output control, channel k at LSB + k
`define DIAG_EN_LSB      1
`define TWEETER_MODE_BIT 5
`define HIZ_LSB          1
`define MUTE_BIT         4
`define CLEAR_BIT        7
// thermal status fields
`define THERM_FOLD_LSB   1
`define THERM_OTS_LSB    5
// timing
`define REF_CLK_KHZ      50000
`define REF_PERIOD_NS    20
`define FS_FAST_KHZ      500
`define FS_MID_KHZ       417
`define FS_SLOW_KHZ      357
`define OC_TIME_NS       10000

`endif

// ### inc/amp_pkg.sv
// Purpose: types shared by the amplifier control block and its link engine
// Assumes: amp_consts.svh gives the channel count
// Notes:   state codes are Gray along standby, hi-z, mute, play
`include "amp_consts.svh"
package amp_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY = 2'h0,
    ST_HIZ     = 2'h1,
    ST_MUTE    = 2'h3,
    ST_PLAY    = 2'h2
  } amp_state_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0, L_ADDR = 3'h1, L_ACK_A = 3'h3, L_RX = 3'h2,
    L_ACK_W = 3'h6, L_TX = 3'h7, L_MACK = 3'h5, L_LOAD = 3'h4
  } link_state_t;

  // analog monitor levels, one bit per channel where doubled
  typedef struct packed {
    logic                 por;
    logic                 uv;
    logic                 ov;
    logic                 ot_warn;
    logic [`CH_COUNT-1:0] ot_shut;
    logic [`CH_COUNT-1:0] fold;
    logic [`CH_COUNT-1:0] cbc;
    logic [`CH_COUNT-1:0] clip;
    logic [`CH_COUNT-1:0] dc_fault;
    logic [`CH_COUNT-1:0] tweeter;
    logic [`CH_COUNT-1:0] diag_open;
    logic [`CH_COUNT-1:0] diag_short;
  } sense_t;

  typedef struct packed {
    logic [7:0] switch_ctrl;
    logic [7:0] diag_ctrl;
    logic [7:0] output_ctrl;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] fault_cause;
    logic [7:0] diag_result;
    logic [7:0] thermal;
  } status_t;
endpackage

// ### hw/bit_sync.sv
// Purpose: two-flop synchroniser for independent level bits
// Assumes: each bit is a level; words need their own handshake
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // plain two-stage capture
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### hw/i2c_target.sv
// Purpose: i2c target byte engine, oversampled on the link clock
// Assumes: link clock at least 8x the bus rate; 7-bit address
// Notes:   first written byte sets the pointer, which then auto-increments
`timescale 1ns/1ps
module i2c_target
  import amp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2C
)(
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  output logic            wr_en,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic      [7:0] rd_addr,
  input  wire logic [7:0] rd_data
);
  logic [1:0]  pin_s;
  logic        scl_d, sda_d, rnw, first;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift, rd_ptr;
  link_state_t state;
  wire scl_s = pin_s[1];
  wire sda_s = pin_s[0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start = scl_s & scl_d & sda_d & ~sda_s;
  wire stop = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_done = (bit_cnt == 4'h8);

  bit_sync #(.W(2)) u_pin_sync (.clk(link_clk), .rst(link_rst), .d({scl_in, sda_in}), .q(pin_s));
  assign rd_addr = rd_ptr;

  // sample on scl rise, drive on scl fall so sda is stable while scl is high
  always_ff @(posedge link_clk) begin
    wr_en <= 1'b0;
    if (link_rst) begin
      state <= L_IDLE; sda_oe <= 1'b0; bit_cnt <= 4'h0; shift <= 8'h00; rd_ptr <= 8'h00;
      rnw <= 1'b0; first <= 1'b0; wr_addr <= 8'h00; wr_data <= 8'h00; scl_d <= 1'b0; sda_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (start) begin
        state <= L_ADDR; bit_cnt <= 4'h0; sda_oe <= 1'b0;
      end else if (stop) begin
        state <= L_IDLE; sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          L_ADDR, L_RX: begin
            shift <= {shift[6:0], sda_s}; bit_cnt <= bit_cnt + 4'h1;
          end
          L_MACK: if (sda_s) state <= L_IDLE; else begin
            rd_ptr <= rd_ptr + 8'h01; state <= L_LOAD;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          L_ADDR: if (byte_done) begin
            bit_cnt <= 4'h0;
            if (shift[7:1] == DEV_ADDR) begin
              sda_oe <= 1'b1; rnw <= shift[0]; state <= L_ACK_A;
            end else state <= L_IDLE;
          end
          L_ACK_A, L_LOAD: if (rnw) begin
            shift <= rd_data; sda_oe <= ~rd_data[7]; bit_cnt <= 4'h1; state <= L_TX;
          end else begin
            sda_oe <= 1'b0; first <= 1'b1; state <= L_RX;
          end
          L_RX: if (byte_done) begin
            bit_cnt <= 4'h0; sda_oe <= 1'b1; state <= L_ACK_W; first <= 1'b0;
            if (first) rd_ptr <= shift;
            else begin
              wr_en <= 1'b1; wr_addr <= rd_ptr; wr_data <= shift; rd_ptr <= rd_ptr + 8'h01;
            end
          end
          L_ACK_W: begin
            sda_oe <= 1'b0; state <= L_RX;
          end
          L_TX: if (byte_done) begin
            sda_oe <= 1'b0; state <= L_MACK;
          end else begin
            shift <= {shift[6:0], 1'b0}; sda_oe <= ~shift[6]; bit_cnt <= bit_cnt + 4'h1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ### hw/amp_fault_state_control.sv
// Purpose: states, fault latching, switching phase and registers of a two-channel amplifier
// Assumes: sense and pins are async levels; link_clk oversamples the i2c pins
// Notes:   registers live in the link domain, faults in the ref_clk domain
//
// Notes on behaviour
// - thermal status resets to zero; D1/D2 flag foldback.
// - D5/D6 flag overtemperature shutdown; other bits read zero.
// - fault pin low when a fault forces hi-z or standby.
// - fault cause read over i2c, except por, which holds the pin.
// - warning pin shows warning, clipping or both.
// - tweeter-detect mode: a found tweeter asserts the warning pin.
// - mute pin low mutes all channels; release unmutes.
// - standby pin shuts down, restores defaults, frees the i2c lines.
// - channels switch 45 or 180 degrees apart, chosen over i2c.
// - standby floats, hi-z pulls down weakly, mute switches at half duty.
// - por: pin, standby, self-clear; uv/ov: report, hi-z, latched.
// - warning only reported; thermal shutdown forces standby, latched.
// - current over limit in mute or play is clipped and timed.
// - overcurrent or dc fault: report, channel to hi-z, latched.
// - diagnostics in hi-z on request, latched; clip and foldback self-clear.
// - switch D1:D0 pick 500, 417 (default) or 357 khz; never 11.
// - switch D3:D2 pick the warning source, default both.
// - switch D5 set gives 180 degrees, clear 45.
`timescale 1ns/1ps
`include "amp_consts.svh"
module amp_fault_state_control
  import amp_pkg::*;
#(
  parameter int         OC_CYCLES = (`OC_TIME_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS,
  parameter logic [6:0] DEV_ADDR  = 7'h2C  // bus address, arbitrary default
)(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  link_clk,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  standby_n,
  input  wire logic                  mute_n,
  input  wire sense_t                sense,
  output logic                       fault_n_out,
  output logic                       fault_n_oe,
  output logic                       clip_or_thermal_warn_n,
  output amp_state_t [`CH_COUNT-1:0] ch_state,
  output logic       [`CH_COUNT-1:0] hard_mute,
  output logic       [`CH_COUNT-1:0] current_limit,
  output logic       [`CH_COUNT-1:0] pulldown_en,
  output logic       [`CH_COUNT-1:0] diag_run,
  output logic       [`CH_COUNT-1:0] carrier
);
  localparam int PER_FAST = `REF_CLK_KHZ / `FS_FAST_KHZ;
  localparam int PER_MID  = `REF_CLK_KHZ / `FS_MID_KHZ;
  localparam int PER_SLOW = `REF_CLK_KHZ / `FS_SLOW_KHZ;
  localparam int NS = $bits(sense_t);
  localparam int RW = NS + 4;
  localparam int LW = $bits(status_t) + 3;

  // link domain
  logic          link_rst;
  logic [LW-1:0] link_sync;
  status_t       status_l;
  ctrl_t         ctrl_l;
  logic          ctrl_tog, clr_tog;
  logic          wr_en;
  logic [7:0]    wr_addr, wr_data, rd_addr, rd_data;
  status_t       status_r;

  // reset sources and status bits cross as independent levels
  bit_sync #(.W(LW)) u_link_sync (
    .clk (link_clk),
    .rst (1'b0),
    .d   ({sys_rst, ~standby_n, sense.por, status_r}),
    .q   (link_sync)
  );
  assign link_rst = |link_sync[LW-1:LW-3];
  assign status_l = link_sync[LW-4:0];

  i2c_target #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .link_clk (link_clk),
    .link_rst (link_rst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe   (sda_oe),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );
  // open drain: only ever pulls low, released in standby
  assign sda_out = 1'b0;

  // write decode
  wire hit_switch = wr_en & (wr_addr == `REG_SWITCH_CTRL);
  wire hit_diag   = wr_en & (wr_addr == `REG_DIAG_CTRL);
  wire hit_output = wr_en & (wr_addr == `REG_OUTPUT_CTRL);
  wire clear_req  = hit_output & wr_data[`CLEAR_BIT];

  // control registers; each write flips a toggle for the fault domain
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ctrl_l.switch_ctrl <= `SWITCH_CTRL_RST;
      ctrl_l.diag_ctrl   <= `DIAG_CTRL_RST;
      ctrl_l.output_ctrl <= `OUTPUT_CTRL_RST;
      ctrl_tog           <= 1'b0;
      clr_tog            <= 1'b0;
    end else begin
      if (hit_switch)
        ctrl_l.switch_ctrl <= wr_data;
      if (hit_diag)
        ctrl_l.diag_ctrl <= wr_data;
      if (hit_output)
        ctrl_l.output_ctrl <= wr_data & ~(8'h01 << `CLEAR_BIT); // clear bit is a strobe
      if (hit_switch | hit_diag | hit_output)
        ctrl_tog <= ~ctrl_tog;
      if (clear_req)
        clr_tog <= ~clr_tog;
    end
  end

  // read select; unmapped offsets read zero
  assign rd_data = (rd_addr == `REG_SWITCH_CTRL) ? ctrl_l.switch_ctrl :
                   (rd_addr == `REG_DIAG_CTRL)   ? ctrl_l.diag_ctrl :
                   (rd_addr == `REG_OUTPUT_CTRL) ? ctrl_l.output_ctrl :
                   (rd_addr == `REG_FAULT_CAUSE) ? status_l.fault_cause :
                   (rd_addr == `REG_DIAG_RESULT) ? status_l.diag_result :
                   (rd_addr == `REG_THERMAL)     ? status_l.thermal : 8'h00;

  // ref_clk domain
  logic [RW-1:0] ref_sync;
  sense_t        sn;
  logic          standby_req, mute_req, ctrl_tog_s, clr_tog_s;
  logic          ctrl_tog_d, clr_tog_d;
  ctrl_t         ctrl_r;

  bit_sync #(.W(RW)) u_ref_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({~standby_n, ~mute_n, ctrl_tog, clr_tog, sense}),
    .q   (ref_sync)
  );
  assign standby_req = ref_sync[RW-1];
  assign mute_req    = ref_sync[RW-2];
  assign ctrl_tog_s  = ref_sync[RW-3];
  assign clr_tog_s   = ref_sync[RW-4];
  assign sn          = ref_sync[NS-1:0];

  wire hard_clr  = sys_rst | standby_req | sn.por;
  wire ctrl_chg  = ctrl_tog_s ^ ctrl_tog_d;
  wire clr_pulse = clr_tog_s ^ clr_tog_d;

  // toggle edge detect; the link word settles long before its toggle arrives
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_tog_d <= 1'b0;
      clr_tog_d  <= 1'b0;
    end else begin
      ctrl_tog_d <= ctrl_tog_s;
      clr_tog_d  <= clr_tog_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (hard_clr)
      ctrl_r <= {`SWITCH_CTRL_RST, `DIAG_CTRL_RST, `OUTPUT_CTRL_RST};
    else if (ctrl_chg)
      ctrl_r <= ctrl_l;
  end

  // control fields
  wire [1:0]           freq_sel = ctrl_r.switch_ctrl[`FREQ_LSB +: 2];
  wire [1:0]           warn_cfg = ctrl_r.switch_ctrl[`WARN_CFG_LSB +: 2];
  wire                 phase180 = ctrl_r.switch_ctrl[`PHASE180_BIT];
  wire [`CH_COUNT-1:0] diag_en  = ctrl_r.diag_ctrl[`DIAG_EN_LSB +: `CH_COUNT];
  wire                 tw_mode  = ctrl_r.diag_ctrl[`TWEETER_MODE_BIT];
  wire [`CH_COUNT-1:0] hiz_bit  = ctrl_r.output_ctrl[`HIZ_LSB +: `CH_COUNT];
  wire                 mute_bit = ctrl_r.output_ctrl[`MUTE_BIT];

  // latched faults
  logic                 uv_l, ov_l;
  logic [`CH_COUNT-1:0] ots_l, oc_l, dc_l, open_l, short_l;
  logic [`CH_COUNT-1:0] ch_active, oc_trip;

  wire glob_standby = |ots_l;
  wire glob_hiz     = uv_l | ov_l;
  wire monitor      = ~glob_standby;
  wire [`CH_COUNT-1:0] ch_fault = oc_l | dc_l;

  // set wins over a host clear arriving in the same cycle
  always_ff @(posedge ref_clk) begin
    if (hard_clr) begin
      uv_l    <= 1'b0;
      ov_l    <= 1'b0;
      ots_l   <= '0;
      oc_l    <= '0;
      dc_l    <= '0;
      open_l  <= '0;
      short_l <= '0;
    end else begin
      uv_l    <= (uv_l & ~clr_pulse) | (monitor & sn.uv);
      ov_l    <= (ov_l & ~clr_pulse) | (monitor & sn.ov);
      ots_l   <= (ots_l & ~{`CH_COUNT{clr_pulse}}) | ({`CH_COUNT{monitor}} & sn.ot_shut);
      oc_l    <= (oc_l & ~{`CH_COUNT{clr_pulse}}) | oc_trip;
      dc_l    <= (dc_l & ~{`CH_COUNT{clr_pulse}}) | (ch_active & sn.dc_fault);
      open_l  <= (open_l & ~{`CH_COUNT{clr_pulse}}) | (diag_run & sn.diag_open);
      short_l <= (short_l & ~{`CH_COUNT{clr_pulse}}) | (diag_run & sn.diag_short);
    end
  end

  // carrier base count at the selected period
  logic [7:0] period, offset, base_cnt;
  assign period = (freq_sel == `FS_CODE_FAST) ? PER_FAST[7:0] :
                  (freq_sel == `FS_CODE_SLOW) ? PER_SLOW[7:0] : PER_MID[7:0];
  assign offset = phase180 ? {1'b0, period[7:1]} : {3'h0, period[7:3]};

  always_ff @(posedge ref_clk) begin
    if (sys_rst | (base_cnt >= period - 8'h01))
      base_cnt <= 8'h00;
    else
      base_cnt <= base_cnt + 8'h01;
  end

  // per-channel state, protection timer and carrier
  genvar k;
  generate
    for (k = 0; k < `CH_COUNT; k++) begin : g_ch
      amp_state_t next_state;
      logic [8:0] lag, raw;
      logic [7:0] ph;
      logic [15:0] oc_cnt;

      // priority: standby, then hi-z, then mute, then play
      assign next_state = glob_standby ? ST_STANDBY :
                          (glob_hiz | ch_fault[k] | hiz_bit[k]) ? ST_HIZ :
                          (mute_req | mute_bit) ? ST_MUTE : ST_PLAY;
      assign ch_active[k] = (ch_state[k] == ST_MUTE) | (ch_state[k] == ST_PLAY);

      always_ff @(posedge ref_clk) begin
        if (hard_clr)
          ch_state[k] <= ST_STANDBY;
        else
          ch_state[k] <= next_state;
      end

      // overcurrent timer runs while the cycle limit holds
      assign oc_trip[k] = (oc_cnt == 16'(OC_CYCLES));
      always_ff @(posedge ref_clk) begin
        if (hard_clr | ~sn.cbc[k] | ~ch_active[k])
          oc_cnt <= 16'h0000;
        else if (oc_cnt < 16'(OC_CYCLES))
          oc_cnt <= oc_cnt + 16'h0001;
      end

      // channel k lags by k*offset, below one period with two channels
      assign lag = 9'(k) * {1'b0, offset};
      assign raw = {1'b0, base_cnt} + {1'b0, period} - lag;
      assign ph  = (raw >= {1'b0, period}) ? 8'(raw - {1'b0, period}) : raw[7:0];

      always_ff @(posedge ref_clk) begin
        if (hard_clr) begin
          carrier[k]       <= 1'b0;
          current_limit[k] <= 1'b0;
          hard_mute[k]     <= 1'b1;
          pulldown_en[k]   <= 1'b0;
          diag_run[k]      <= 1'b0;
        end else begin
          carrier[k]       <= ch_active[k] & (ph < {1'b0, period[7:1]});
          current_limit[k] <= ch_active[k] & (sn.cbc[k] | sn.fold[k]);
          hard_mute[k]     <= glob_standby | ch_fault[k];
          pulldown_en[k]   <= (ch_state[k] == ST_HIZ);
          diag_run[k]      <= diag_en[k] & (ch_state[k] == ST_HIZ);
        end
      end
    end
  endgenerate

  // warning source select; tweeter term ORed in while that mode runs
  wire clip_any  = |(sn.clip & ch_active);
  wire therm_any = (monitor & sn.ot_warn) | (|sn.fold);
  wire tw_any    = tw_mode & (|sn.tweeter);
  wire warn_sel  = (warn_cfg == `WARN_CLIP)  ? clip_any :
                   (warn_cfg == `WARN_THERM) ? therm_any :
                   (warn_cfg == `WARN_BOTH)  ? (clip_any | therm_any) : 1'b0;

  // pins; fault pin held through por while i2c is down
  assign fault_n_out = 1'b0;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fault_n_oe             <= 1'b0;
      clip_or_thermal_warn_n <= 1'b1;
    end else begin
      fault_n_oe             <= sn.por | glob_hiz | glob_standby | (|ch_fault);
      clip_or_thermal_warn_n <= ~(warn_sel | tw_any);
    end
  end

  // status words handed to the link domain
  always_ff @(posedge ref_clk) begin
    if (hard_clr) begin
      status_r.fault_cause <= 8'h00;
      status_r.diag_result <= 8'h00;
      status_r.thermal     <= `THERMAL_RST;
    end else begin
      status_r.fault_cause <= {sn.ot_warn, dc_l, oc_l, glob_standby, ov_l, uv_l};
      status_r.diag_result <= {4'h0, short_l, open_l};
      status_r.thermal     <= ((8'(sn.fold) << `THERM_FOLD_LSB) |
                               (8'(ots_l) << `THERM_OTS_LSB));
    end
  end
endmodule

// ### testbench/amp_host_model.sv
// Purpose: i2c bus master standing in for the host controller
// Assumes: bus lines pulled up; target oversamples on its link clock
// Notes:   480 ns bit time; single-byte reads end with a nack
`timescale 1ns/1ps
module amp_host_model #(
  parameter logic [6:0] ADDR = 7'h2C
)(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int Q = 120;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit; line sampled mid-high, a released bit reads the pull-up
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // start from idle, or repeated start in mid-frame
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // byte msb first, ninth bit left released
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    logic n;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, n);
  endtask
  // callers never send frequency code 11 over the bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({ADDR, 1'b0}, q);
    byte_io(a, q);
    byte_io(d, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    byte_io({ADDR, 1'b0}, d);
    byte_io(a, d);
    start();
    byte_io({ADDR, 1'b1}, d);
    byte_io(8'hFF, d);
    stop();
  endtask
endmodule

// ### testbench/amp_props.sv
// Purpose: port-level checks of the amplifier control block
// Assumes: async inputs reach the outputs within 2 to 6 ref_clk
// Notes:   link-side outputs are only checked after long holds
`timescale 1ns/1ps
`include "amp_consts.svh"
module amp_props
  import amp_pkg::*;
(
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire logic                       standby_n,
  input wire logic                       mute_n,
  input wire sense_t                     sense,
  input wire logic                       sda_oe,
  input wire logic                       fault_n_oe,
  input wire amp_state_t [`CH_COUNT-1:0] ch_state,
  input wire logic [`CH_COUNT-1:0]       hard_mute,
  input wire logic [`CH_COUNT-1:0]       current_limit,
  input wire logic [`CH_COUNT-1:0]       pulldown_en,
  input wire logic [`CH_COUNT-1:0]       carrier
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // state and fault relations, bounded by the sync latency
  stby_release_a: assert property (!standby_n [*8] |-> ch_state == {ST_STANDBY, ST_STANDBY} && !sda_oe)
    else $error("standby not entered");
  por_standby_a: assert property (sense.por [*6] |-> fault_n_oe && ch_state[0] == ST_STANDBY && hard_mute[0])
    else $error("por not handled");
  uv_report_a: assert property ($rose(sense.uv) && ch_state[0] != ST_STANDBY |-> ##[2:5] fault_n_oe)
    else $error("uv not flagged");
  ots_standby_a: assert property ($rose(sense.ot_shut[0]) && ch_state[0] != ST_STANDBY
    |-> ##[2:6] fault_n_oe && ch_state[0] == ST_STANDBY) else $error("ot shutdown missed");
  dc_hiz_a: assert property ($rose(sense.dc_fault[1]) && ch_state[1] == ST_PLAY
    |-> ##[2:6] ch_state[1] == ST_HIZ && hard_mute[1]) else $error("dc fault missed");
  cbc_limit_a: assert property (sense.cbc[0] && ch_state[0] == ST_PLAY |-> ##[0:4] current_limit[0])
    else $error("no current limit");
  mute_pin_a: assert property ($fell(mute_n) && ch_state[0] == ST_PLAY |-> ##[2:6] ch_state[0] == ST_MUTE)
    else $error("pin mute ignored");
  hiz_pulldown_a: assert property ((ch_state[1] == ST_HIZ) [*3] |-> !carrier[1] && pulldown_en[1])
    else $error("hi-z outputs wrong");
endmodule
bind amp_fault_state_control amp_props u_amp_props (
  .ref_clk, .sys_rst, .standby_n, .mute_n, .sense, .sda_oe, .fault_n_oe,
  .ch_state, .hard_mute, .current_limit, .pulldown_en, .carrier
);

// ### testbench/tb.sv
// Purpose: self-checking bench for the amplifier control block
// Assumes: host model owns the bus; pins and sense levels driven here
// Notes:   overcurrent time cut to 8 cycles to keep the run short
`timescale 1ns/1ps
`include "amp_consts.svh"
module tb
  import amp_pkg::*;
;
  typedef struct packed {
    logic [7:0] sw;
    logic [1:0] fold;
    logic       clip;
    logic       ot;
    logic       warn;
  } row_t;
  logic             ref_clk = 1'b0;
  logic             link_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             standby_n = 1'b1;
  logic             mute_n = 1'b1;
  sense_t           sense = '0;
  logic             scl, sda_low, sda_oe, sda_out, fault_n_oe, fault_n_out, clip_or_thermal_warn_n;
  amp_state_t [1:0] ch_state;
  logic [1:0]       hard_mute, current_limit, pulldown_en, diag_run, carrier;
  logic [7:0]       rb;
  int               err_count = 0;
  int               n_tests = 0;
  int               cyc;
  int               per [3] = '{100, 119, 140};
  int               lag [3] = '{50, 15, 18};
  logic [7:0]       csw [3] = '{8'h2C, 8'h0D, 8'h0E};
  // switch byte, foldback, clip ch0, warning, expected pin
  row_t rows [9] = '{'{8'h0D, 2'h0, 1'h1, 1'h0, 1'h0}, '{8'h05, 2'h0, 1'h0, 1'h1, 1'h1},
    '{8'h05, 2'h0, 1'h1, 1'h0, 1'h0}, '{8'h09, 2'h0, 1'h1, 1'h0, 1'h1}, '{8'h09, 2'h0, 1'h0, 1'h1, 1'h0},
    '{8'h09, 2'h2, 1'h0, 1'h0, 1'h0}, '{8'h01, 2'h0, 1'h1, 1'h1, 1'h1}, '{8'h0D, 2'h1, 1'h0, 1'h0, 1'h0},
    '{8'h0D, 2'h0, 1'h0, 1'h0, 1'h1}};
  // open drain with pull-up: low while either side pulls
  wire sda = !(sda_low || sda_oe);
  always #10 ref_clk = ~ref_clk;
  // link clock at its own phase
  initial begin
    #3.3;
    forever #6 link_clk = ~link_clk;
  end
  amp_fault_state_control #(.OC_CYCLES(8)) u_amp_fault_state_control (.ref_clk, .sys_rst, .link_clk,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .standby_n, .mute_n, .sense, .fault_n_out, .fault_n_oe,
    .clip_or_thermal_warn_n, .ch_state, .hard_mute, .current_limit, .pulldown_en, .diag_run, .carrier);
  amp_host_model u_amp_host_model (.scl, .sda_low, .sda);
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk_v(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_n(input int g, input int e, input string m);
    n_tests++;
    if (g > e + 1 || g < e - 1) fail(m);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // writes settle 8 cycles so control reaches the ref domain
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_amp_host_model.wr(a, d);
    w(8);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    u_amp_host_model.rd(a, rb);
    chk_v(rb, e, m);
  endtask
  // waits for a carrier rise; a stuck carrier ends the run
  task automatic edge_up(input int c);
    int k = 0;
    for (; k < 400 && carrier[c] !== 1'b0; k++) @(negedge ref_clk);
    for (; k < 400 && carrier[c] !== 1'b1; k++) @(negedge ref_clk);
    cyc += k;
    if (k >= 400) begin
      fail("carrier stuck");
      tally_and_finish();
    end
  endtask
  initial begin
    w(6);
    sys_rst <= 1'b0;
    w(10);
    chk_v(ch_state, {ST_HIZ, ST_HIZ}, "reset state");
    rdc(`REG_THERMAL, `THERMAL_RST, "thermal reset");
    rdc(`REG_SWITCH_CTRL, `SWITCH_CTRL_RST, "switch reset");
    rdc(8'h20, 8'h00, "unmapped");
    wr(`REG_OUTPUT_CTRL, 8'h10);
    chk_v(ch_state, {ST_MUTE, ST_MUTE}, "bus mute");
    wr(`REG_OUTPUT_CTRL, 8'h00);
    chk_v(ch_state, {ST_PLAY, ST_PLAY}, "play");
    foreach (rows[i]) begin
      wr(`REG_SWITCH_CTRL, rows[i].sw);
      sense.fold <= rows[i].fold;
      sense.clip <= {1'b0, rows[i].clip};
      sense.ot_warn <= rows[i].ot;
      w(8);
      chk_v(clip_or_thermal_warn_n, rows[i].warn, "warn pin");
      rdc(`REG_THERMAL, {5'h00, rows[i].fold, 1'b0}, "foldback");
    end
    for (int i = 0; i < 3; i++) begin
      wr(`REG_SWITCH_CTRL, csw[i]);
      w(300);
      edge_up(0);
      cyc = 0;
      edge_up(1);
      chk_n(cyc, lag[i], "phase lag");
      edge_up(0);
      chk_n(cyc, per[i], "period");
    end
    wr(`REG_DIAG_CTRL, 8'h70);
    sense.tweeter <= 2'h1;
    w(8);
    chk_v(clip_or_thermal_warn_n, 1'b0, "tweeter");
    sense.tweeter <= 2'h0;
    mute_n <= 1'b0;
    w(8);
    chk_v(ch_state, {ST_MUTE, ST_MUTE}, "pin mute");
    mute_n <= 1'b1;
    w(8);
    sense.uv <= 1'b1;
    w(8);
    sense.uv <= 1'b0;
    chk_v(ch_state, {ST_HIZ, ST_HIZ}, "uv hi-z");
    w(20);
    chk_v(fault_n_oe, 1'b1, "uv latched");
    rdc(`REG_FAULT_CAUSE, 8'h01, "uv cause");
    wr(`REG_OUTPUT_CTRL, 8'h80);
    chk_v({fault_n_oe, ch_state}, {1'b0, ST_PLAY, ST_PLAY}, "uv cleared");
    sense.cbc <= 2'h1;
    sense.dc_fault <= 2'h2;
    w(5);
    chk_v(current_limit[0], 1'b1, "current limit");
    w(15);
    sense.cbc <= 2'h0;
    sense.dc_fault <= 2'h0;
    chk_v({hard_mute, ch_state}, {2'h3, ST_HIZ, ST_HIZ}, "oc dc hi-z");
    rdc(`REG_FAULT_CAUSE, 8'h48, "oc dc cause");
    wr(`REG_OUTPUT_CTRL, 8'h80);
    standby_n <= 1'b0;
    w(8);
    chk_v(ch_state, {ST_STANDBY, ST_STANDBY}, "standby");
    standby_n <= 1'b1;
    w(10);
    rdc(`REG_SWITCH_CTRL, `SWITCH_CTRL_RST, "defaults back");
    sense.por <= 1'b1;
    w(8);
    chk_v(fault_n_oe, 1'b1, "por fault");
    sense.por <= 1'b0;
    w(10);
    chk_v(fault_n_oe, 1'b0, "por self-clear");
    sense.ot_shut <= 2'h1;
    w(8);
    chk_v(ch_state[0], ST_STANDBY, "ot standby");
    sense.ot_shut <= 2'h0;
    w(10);
    chk_v(fault_n_oe, 1'b1, "ot latched");
    rdc(`REG_THERMAL, 8'h20, "ots status");
    sys_rst <= 1'b1;
    w(6);
    sys_rst <= 1'b0;
    w(4);
    chk_v(fault_n_oe, 1'b0, "reset clears");
    tally_and_finish();
  end
endmodule
